/* common/tcs_consts.vh */
// Constants for the touch conversion sequencer
//
// Contract
// - With no touch, drive Y plate high and X plate low to detect touches.
// - A sensed touch starts conversions only while at-rate conversion is enabled.
// - Pen bounce is ignored until the current X or Y point is finished.
// - A pen lift is recognised only after the running conversion completes.
// - Wait at least one millisecond settling after an interrupt or single-point request.
// - Convert X and Y with the 10-bit converter, repeating at the rate register.
// - Ratiometric: full plate voltage is code 1023, touch gives proportional code.
// - Pressure measurement only in four-wire mode; host never requests it in five-wire.
// - Normal X read drives X-high high, X-low to ground, senses other plate.
// - Normal X measurement takes the Y-high electrode voltage as the result.
// - Pressure with flag 1 drives X-high, Y-low; senses Y-high (A) or X-low (B).
// - Single-point request in a pressure mode runs two flagged conversions automatically.
// - Six drive-and-sense configurations from two pressure bits and flag; results 0..1023.
// - Raise the interrupt on touch status change and on conversion completion.
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCS_REG_CTRL     8'h00
`define TCS_REG_RATE     8'h04
`define TCS_REG_RES0     8'h08
`define TCS_REG_RES1     8'h0C
`define TCS_REG_STATUS   8'h10
`define TCS_REG_MASK     8'h14
`define TCS_REG_STATE    8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCS_CTRL_ENA     0
`define TCS_CTRL_SPR     1
`define TCS_CTRL_PRA     2
`define TCS_CTRL_PRB     3
`define TCS_CTRL_W5      4
`define TCS_ST_TOUCH     0
`define TCS_ST_DONE      1
`define TCS_RES_FLAG     10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCS_CTRL_RST     5'h00
`define TCS_RATE_RST     8'h20
`define TCS_MASK_RST     2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCS_CLK_PERIOD_NS 4
`define TCS_SETTLE_NS     1000000
// One millisecond of 4 ns cycles, sized for the settle counter
`define TCS_SETTLE_CYC    20'h3_D090
`define TCS_RATE_STEP_CYC 13'h1000

`endif

/* src/tcs_seq.v */
// Touch screen conversion sequencer with register port and interrupt
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tcs_consts.vh"

module tcs_seq #(
  parameter [19:0] SETTLE_CYCLES = `TCS_SETTLE_CYC,
  parameter [12:0] RATE_STEP     = `TCS_RATE_STEP_CYC
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  addr,
  input  wire [31:0] wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rd_data_q,
  output reg         irq_q,
  input  wire        touch_sense,
  output reg         x_plate_high_end_out_q,
  output reg         x_plate_high_end_oe_n_q,
  output reg         x_plate_low_end_out_q,
  output reg         x_plate_low_end_oe_n_q,
  output reg         y_plate_high_end_out_q,
  output reg         y_plate_high_end_oe_n_q,
  output reg         y_plate_low_end_out_q,
  output reg         y_plate_low_end_oe_n_q,
  output reg  [1:0]  sense_sel_q,
  output reg         adc_start_q,
  input  wire        adc_done,
  input  wire [9:0]  adc_data
);

  // ----------------------------------------------------------------
  // States and encodings
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'd0;
  localparam [2:0] S_SETTLE = 3'd1;
  localparam [2:0] S_STARTY = 3'd2;
  localparam [2:0] S_WAITY  = 3'd3;
  localparam [2:0] S_STARTX = 3'd4;
  localparam [2:0] S_WAITX  = 3'd5;
  localparam [2:0] S_GAP    = 3'd6;
  localparam [2:0] S_CHECK  = 3'd7;

  // Sensed electrode codes
  localparam [1:0] SN_XH = 2'd0;
  localparam [1:0] SN_XL = 2'd1;
  localparam [1:0] SN_YH = 2'd2;
  localparam [1:0] SN_YL = 2'd3;

  // Measurement modes
  localparam [1:0] M_NORM = 2'd0;
  localparam [1:0] M_PRA  = 2'd1;
  localparam [1:0] M_PRB  = 2'd2;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         ena_q;
  reg         spr_q;
  reg         pra_q;
  reg         prb_q;
  reg         w5_q;
  reg  [7:0]  rate_q;
  reg  [10:0] res0_q;
  reg  [10:0] res1_q;
  reg  [1:0]  status_q;
  reg  [1:0]  mask_q;
  reg         touch_q;
  reg         single_q;
  reg  [1:0]  mode_q;
  reg  [1:0]  mode_d;
  reg         xy_result_flag;
  reg  [19:0] cnt_q;
  reg  [12:0] step_q;
  reg  [7:0]  units_q;

  reg         set_touch;
  reg         set_done;
  reg         clr_spr;
  reg         touch_d;
  reg         single_d;
  reg         cnt_clr;
  reg         flag_d;
  reg  [7:0]  drv_d;
  reg  [1:0]  sense_d;
  reg  [1:0]  status_d;
  reg  [31:0] rd_mux;

  wire        wr_ctrl   = wr_en && (addr == `TCS_REG_CTRL);
  wire        wr_rate   = wr_en && (addr == `TCS_REG_RATE);
  wire        wr_status = wr_en && (addr == `TCS_REG_STATUS);
  wire        wr_mask   = wr_en && (addr == `TCS_REG_MASK);
  wire        settle_end = (cnt_q >= SETTLE_CYCLES - 20'd1);
  wire        gap_end    = (units_q >= rate_q) &&
                           (step_q >= RATE_STEP - 13'd1);

  // Pressure bits count only on a four-wire screen
  wire [1:0]  mode_sel = w5_q ? M_NORM :
                         prb_q ? M_PRB : (pra_q ? M_PRA : M_NORM);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_d   = state_q;
    set_touch = 1'b0;
    set_done  = 1'b0;
    clr_spr   = 1'b0;
    touch_d   = touch_q;
    single_d  = single_q;
    mode_d    = mode_q;
    flag_d    = xy_result_flag;
    cnt_clr   = 1'b1;
    case (state_q)
      S_IDLE: begin
        flag_d = 1'b0;
        if (spr_q) begin
          single_d = 1'b1;
          mode_d   = mode_sel;
          state_d  = S_SETTLE;
        end else if (touch_sense && ena_q) begin
          touch_d   = 1'b1;
          set_touch = 1'b1;
          single_d  = 1'b0;
          mode_d    = M_NORM;
          state_d   = S_SETTLE;
        end
      end
      S_SETTLE: begin
        cnt_clr = 1'b0;
        if (settle_end) begin
          state_d = S_STARTY;
        end
      end
      S_STARTY: begin
        state_d = S_WAITY;
      end
      S_WAITY: begin
        // Touch input is not looked at while a point is taken
        if (adc_done) begin
          flag_d  = 1'b1;
          state_d = S_STARTX;
        end
      end
      S_STARTX: begin
        state_d = S_WAITX;
      end
      S_WAITX: begin
        if (adc_done) begin
          set_done = 1'b1;
          flag_d   = 1'b0;
          if (single_q) begin
            clr_spr  = 1'b1;
            single_d = 1'b0;
            state_d  = S_IDLE;
          end else begin
            state_d = S_GAP;
          end
        end
      end
      S_GAP: begin
        if (gap_end) begin
          state_d = S_CHECK;
        end
      end
      S_CHECK: begin
        if (touch_sense && ena_q) begin
          state_d = S_SETTLE;
        end else begin
          touch_d   = 1'b0;
          set_touch = 1'b1;
          state_d   = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Plate drive and sensed pin
  // ----------------------------------------------------------------
  // drv_d = {xh_out, xl_out, yh_out, yl_out, xh_oe_n, xl_oe_n,
  //          yh_oe_n, yl_oe_n}; an undriven end floats for sensing
  always @* begin
    drv_d   = 8'h00;
    sense_d = SN_XH;
    case (state_d)
      S_IDLE, S_GAP, S_CHECK: begin
        drv_d   = 8'b0011_0000;
        sense_d = SN_XH;
      end
      default: begin
        case ({mode_d, flag_d})
          {M_NORM, 1'b0}: begin
            drv_d   = 8'b0010_1100;
            sense_d = SN_XH;
          end
          {M_NORM, 1'b1}: begin
            drv_d   = 8'b1000_0011;
            sense_d = SN_YH;
          end
          {M_PRA, 1'b0}: begin
            drv_d   = 8'b0010_1001;
            sense_d = SN_XH;
          end
          {M_PRA, 1'b1}: begin
            drv_d   = 8'b1000_0110;
            sense_d = SN_YH;
          end
          {M_PRB, 1'b0}: begin
            drv_d   = 8'b0010_1001;
            sense_d = SN_YL;
          end
          {M_PRB, 1'b1}: begin
            drv_d   = 8'b1000_0110;
            sense_d = SN_XL;
          end
          default: begin
            drv_d   = 8'b0011_0000;
            sense_d = SN_XH;
          end
        endcase
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q        <= S_IDLE;
      touch_q        <= 1'b0;
      single_q       <= 1'b0;
      mode_q         <= M_NORM;
      xy_result_flag <= 1'b0;
      cnt_q          <= 20'h0_0000;
      step_q         <= 13'h0000;
      units_q        <= 8'h00;
      adc_start_q    <= 1'b0;
      sense_sel_q    <= SN_XH;
      {x_plate_high_end_out_q, x_plate_low_end_out_q,
       y_plate_high_end_out_q, y_plate_low_end_out_q} <= 4'h3;
      {x_plate_high_end_oe_n_q, x_plate_low_end_oe_n_q,
       y_plate_high_end_oe_n_q, y_plate_low_end_oe_n_q} <= 4'h0;
    end else begin
      state_q        <= state_d;
      touch_q        <= touch_d;
      single_q       <= single_d;
      mode_q         <= mode_d;
      xy_result_flag <= flag_d;
      cnt_q          <= cnt_clr ? 20'h0_0000 : cnt_q + 20'h0_0001;
      if (state_q != S_GAP) begin
        step_q  <= 13'h0000;
        units_q <= 8'h00;
      end else if (step_q >= RATE_STEP - 13'd1) begin
        step_q  <= 13'h0000;
        units_q <= units_q + 8'h01;
      end else begin
        step_q <= step_q + 13'h0001;
      end
      adc_start_q <= (state_d == S_STARTY) || (state_d == S_STARTX);
      sense_sel_q <= sense_d;
      {x_plate_high_end_out_q, x_plate_low_end_out_q,
       y_plate_high_end_out_q, y_plate_low_end_out_q} <= drv_d[7:4];
      {x_plate_high_end_oe_n_q, x_plate_low_end_oe_n_q,
       y_plate_high_end_oe_n_q, y_plate_low_end_oe_n_q} <= drv_d[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  // Converter code is stored unaltered, 1023 meaning full plate voltage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res0_q <= 11'h000;
      res1_q <= 11'h000;
    end else if (adc_done && (state_q == S_WAITY)) begin
      res0_q <= {xy_result_flag, adc_data};
    end else if (adc_done && (state_q == S_WAITX)) begin
      res1_q <= {xy_result_flag, adc_data};
    end
  end

  // ----------------------------------------------------------------
  // Control, rate, status and mask registers
  // ----------------------------------------------------------------
  always @* begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~wr_data[1:0];
    end
    // Events win over a simultaneous write-one-to-clear
    status_d[`TCS_ST_TOUCH] = status_d[`TCS_ST_TOUCH] | set_touch;
    status_d[`TCS_ST_DONE]  = status_d[`TCS_ST_DONE] | set_done;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {w5_q, prb_q, pra_q, spr_q, ena_q} <= `TCS_CTRL_RST;
      rate_q   <= `TCS_RATE_RST;
      status_q <= 2'h0;
      mask_q   <= `TCS_MASK_RST;
      irq_q    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ena_q <= wr_data[`TCS_CTRL_ENA];
        pra_q <= wr_data[`TCS_CTRL_PRA];
        prb_q <= wr_data[`TCS_CTRL_PRB];
        w5_q  <= wr_data[`TCS_CTRL_W5];
        spr_q <= wr_data[`TCS_CTRL_SPR];
      end else if (clr_spr) begin
        spr_q <= 1'b0;
      end
      if (wr_rate) begin
        rate_q <= wr_data[7:0];
      end
      if (wr_mask) begin
        mask_q <= wr_data[1:0];
      end
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `TCS_REG_CTRL:   rd_mux = {27'h000_0000, w5_q, prb_q, pra_q,
                                 spr_q, ena_q};
      `TCS_REG_RATE:   rd_mux = {24'h00_0000, rate_q};
      `TCS_REG_RES0:   rd_mux = {21'h00_0000, res0_q};
      `TCS_REG_RES1:   rd_mux = {21'h00_0000, res1_q};
      `TCS_REG_STATUS: rd_mux = {30'h0000_0000, status_q};
      `TCS_REG_MASK:   rd_mux = {30'h0000_0000, mask_q};
      `TCS_REG_STATE:  rd_mux = {26'h000_0000, single_q, state_q,
                                 (state_q != S_IDLE), touch_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // tcs_seq

`default_nettype wire

/* sim/tcs_seq_properties.sv */
// Port assertions for the touch conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tcs_seq_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data_q,
  input wire logic        irq_q,
  input wire logic        x_plate_high_end_out_q,
  input wire logic        x_plate_high_end_oe_n_q,
  input wire logic        x_plate_low_end_out_q,
  input wire logic        x_plate_low_end_oe_n_q,
  input wire logic        y_plate_high_end_out_q,
  input wire logic        y_plate_high_end_oe_n_q,
  input wire logic        y_plate_low_end_out_q,
  input wire logic        y_plate_low_end_oe_n_q,
  input wire logic [1:0]  sense_sel_q,
  input wire logic        adc_start_q,
  input wire logic        adc_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [3:0] oe_n = {x_plate_high_end_oe_n_q, x_plate_low_end_oe_n_q,
                     y_plate_high_end_oe_n_q, y_plate_low_end_oe_n_q};
  wire       idle = (oe_n == 4'h0) & y_plate_high_end_out_q &
                    y_plate_low_end_out_q & ~x_plate_high_end_out_q &
                    ~x_plate_low_end_out_q;
  // Driven high ends sit high, driven low ends sit low
  wire       lvl_ok = (x_plate_high_end_oe_n_q | x_plate_high_end_out_q) &
                      (y_plate_high_end_oe_n_q | y_plate_high_end_out_q) &
                      (x_plate_low_end_oe_n_q | ~x_plate_low_end_out_q) &
                      (y_plate_low_end_oe_n_q | ~y_plate_low_end_out_q);
  // High from a start until the converter reports done
  logic      conv_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_q <= 1'b0;
    end else if (adc_start_q) begin
      conv_q <= 1'b1;
    end else if (adc_done) begin
      conv_q <= 1'b0;
    end
  end
  sequence s_leave_idle;
    idle ##1 !idle;
  endsequence
  // Figures assume a settle count of 10 cycles
  sequence s_settle;
    !adc_start_q [*8] ##1 !adc_start_q ##[1:2] adc_start_q;
  endsequence
  a_reset_idle: assert property ($rose(reset_n) |-> idle)
    else $error("plates not in touch-detect pattern after reset");
  a_settle_wait: assert property (s_leave_idle |-> s_settle)
    else $error("conversion start not after settle time");
  a_start_once: assert property (conv_q |-> !adc_start_q)
    else $error("second start before converter finished");
  a_hold_drive: assert property (
    conv_q |-> $stable(oe_n) && $stable(sense_sel_q))
    else $error("drive changed during conversion");
  a_sense_free: assert property (
    adc_start_q |-> oe_n[~sense_sel_q] && $countones(oe_n) == 2 && lvl_ok)
    else $error("bad drive or sense pattern at start");
  a_read_window: assert property (
    !$past(rd_en) |-> rd_data_q == 32'h0000_0000)
    else $error("read data outside read window");
  a_unmapped_zero: assert property (
    rd_en && addr > 8'h18 |=> rd_data_q == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_mask_quiet: assert property (
    wr_en && addr == 8'h14 && wr_data[1:0] == 2'h0 |-> ##2 !irq_q)
    else $error("interrupt high with all sources masked");
endmodule // tcs_seq_properties
`default_nettype wire

/* sim/tcs_touch_model.sv */
// Behavioural four-wire touch screen and converter
`timescale 1ns/100ps
`default_nettype none
module tcs_touch_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       pen,
  input  wire logic       slow,
  input  wire logic [7:0] plate,
  input  wire logic [1:0] sense_sel_q,
  input  wire logic       adc_start_q,
  output var  logic       touch_sense,
  output var  logic       adc_done,
  output var  logic [9:0] adc_data
);
  logic [4:0] cnt_q;
  // Touch pulls X up only while Y is driven high
  assign touch_sense = pen & plate[3] & ~plate[2];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q    <= 5'h00;
      adc_done <= 1'b0;
      adc_data <= 10'h000;
    end else begin
      adc_done <= (cnt_q == 5'h01);
      // Code names sense pin and drive; data flips outside done
      adc_data <= (cnt_q == 5'h01) ? {sense_sel_q, plate[6], plate[4],
                  plate[2], plate[0], 4'h5} : ~adc_data;
      if (adc_start_q)
        cnt_q <= slow ? 5'h14 : 5'h03;
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule // tcs_touch_model
`default_nettype wire

/* sim/tcs_seq_tb_top.sv */
// Self-checking bench for the touch conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tcs_seq_tb_top;
  logic        clk;
  logic        reset_n;
  logic        wr_en;
  logic        rd_en;
  logic        pen;
  logic        slow;
  logic        irq_q;
  logic        touch_sense;
  logic        adc_start_q;
  logic        adc_done;
  logic [1:0]  sense_sel_q;
  logic [7:0]  addr;
  logic [7:0]  pl;
  logic [9:0]  adc_data;
  logic [31:0] wr_data;
  logic [31:0] rd_data_q;
  logic [31:0] d;
  int          n_errors = 0;
  int          check_count = 0;
  int          n_start = 0;
  int          cyc = 0;

  tcs_seq #(.SETTLE_CYCLES(20'h0_000A), .RATE_STEP(13'h0004)) i_dut (
    .clk, .reset_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q, .irq_q,
    .touch_sense, .x_plate_high_end_out_q(pl[7]),
    .x_plate_high_end_oe_n_q(pl[6]), .x_plate_low_end_out_q(pl[5]),
    .x_plate_low_end_oe_n_q(pl[4]), .y_plate_high_end_out_q(pl[3]),
    .y_plate_high_end_oe_n_q(pl[2]), .y_plate_low_end_out_q(pl[1]),
    .y_plate_low_end_oe_n_q(pl[0]), .sense_sel_q, .adc_start_q,
    .adc_done, .adc_data);

  tcs_touch_model i_scr (
    .clk, .reset_n, .pen, .slow, .plate(pl), .sense_sel_q, .adc_start_q,
    .touch_sense, .adc_done, .adc_data);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (adc_start_q === 1'b1)
      n_start <= n_start + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out;
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rc(input string s, input logic [7:0] a,
                    input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data_q;
    chk(s, e, d);
  endtask

  task automatic wait_irq;
    #1;
    repeat (400) if (irq_q !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    chk("irq", 32'h1, {31'h0, irq_q});
  endtask

  task automatic t_regs;
    chk("idle drive", 8'h0A, pl);
    rc("ctrl", 8'h00, 8'h00);
    rc("rate", 8'h04, 8'h20);
    rc("mask", 8'h14, 8'h00);
    wr(8'h1C, 32'hFFFF_FFFF);
    rc("unmapped", 8'h1C, 8'h00);
  endtask

  task automatic t_noena;
    int k;
    wr(8'h14, 8'h03);
    k = n_start;
    pen <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk("starts", k, n_start);
    chk("irq off", 8'h00, {31'h0, irq_q});
    pen <= 1'b0;
  endtask

  task automatic t_single;
    logic [5:0] t0 [4] = '{6'h0C, 6'h09, 6'h39, 6'h0C};
    logic [5:0] t1 [4] = '{6'h23, 6'h26, 6'h16, 6'h23};
    logic [4:0] cv;
    wr(8'h14, 8'h02);
    // Last pass is a plain read on a five-wire screen
    for (int m = 0; m < 4; m++) begin
      cv = (m == 3) ? 5'h10 : {1'b0, m[1:0], 2'b00};
      wr(8'h00, cv);
      wr(8'h00, cv | 5'h02);
      wait_irq;
      rc("res0", 8'h08, {t0[m], 4'h5});
      rc("res1", 8'h0C, {1'b1, t1[m], 4'h5});
      rc("ctrl", 8'h00, cv);
      wr(8'h10, 8'h02);
      rc("status", 8'h10, 8'h00);
      chk("irq clear", 8'h00, {31'h0, irq_q});
    end
  endtask

  task automatic t_rate;
    int t;
    wr(8'h14, 8'h03);
    wr(8'h00, 8'h01);
    slow <= 1'b1;
    pen <= 1'b1;
    wait_irq;
    rc("touch", 8'h10, 8'h01);
    wr(8'h10, 8'h01);
    #1;
    repeat (100) if (adc_start_q !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    pen <= 1'b0;
    wait_irq;
    t = cyc;
    rc("pair done", 8'h10, 8'h02);
    rc("res1", 8'h0C, {1'b1, 6'h23, 4'h5});
    wr(8'h10, 8'h02);
    wait_irq;
    // Gap of (rate + 1) steps of 4 cycles, then one check cycle
    chk("gap", 32'd133, cyc - t);
    rc("lift", 8'h10, 8'h01);
    rc("state", 8'h18, 8'h00);
    wr(8'h14, 8'h00);
    @(posedge clk);
    #1;
    chk("irq masked", 8'h00, {31'h0, irq_q});
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h00);
    slow <= 1'b0;
  endtask

  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pen = 1'b0;
    slow = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_noena();
    t_single();
    t_rate();
    close_out();
  end
endmodule // tcs_seq_tb_top

bind tcs_seq tcs_seq_properties i_prop (
  .clk, .reset_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q, .irq_q,
  .x_plate_high_end_out_q, .x_plate_high_end_oe_n_q,
  .x_plate_low_end_out_q, .x_plate_low_end_oe_n_q,
  .y_plate_high_end_out_q, .y_plate_high_end_oe_n_q,
  .y_plate_low_end_out_q, .y_plate_low_end_oe_n_q,
  .sense_sel_q, .adc_start_q, .adc_done);
`default_nettype wire
